// *** rtl/hfds_pkg.sv ***
// Package for the Hall fault and drive select block: types and constants
package hfds_pkg;

  // Synchroniser depth for the comparator outputs
  localparam int SYNC_STAGES = 2;

  // Drive style encodings
  localparam logic DRIVE_SINE = 1'h1;
  localparam logic DRIVE_TRAP = 1'h0;

  // Direction values (forward / reverse)
  localparam logic DIR_FWD = 1'h0;
  localparam logic DIR_REV = 1'h1;

  // Three-phase Hall element input pair
  typedef struct packed {
    logic [2:0] hall_positive_input;
    logic [2:0] hall_negative_input;
  } hfds_hall_in_t;

  // Gate enables for the six output transistors
  typedef struct packed {
    logic [2:0] high_side;
    logic [2:0] low_side;
  } hfds_gate_t;

  // Position state, bit 2 = u, bit 1 = v, bit 0 = w
  typedef logic [2:0] hfds_pos_t;

  // Gate enables when all transistors must be off
  localparam hfds_gate_t GATES_OFF = '{high_side: 3'h0, low_side: 3'h0};

  // Reset value of the synchronised position state (a valid commutation step)
  localparam hfds_pos_t POS_RESET = 3'h5;

endpackage : hfds_pkg

// *** rtl/hfds_top.sv ***
// Hall abnormality detection, rotation direction and drive style selection
// Contract
// R1 - Each phase position signal is the comparison of its positive and negative Hall inputs.
// R2 - With direction select low, forward rotation gives sinusoidal and reverse gives trapezoidal drive.
// R3 - With direction select high, forward rotation gives trapezoidal and reverse gives sinusoidal drive.
// R4 - All three position signals high or all low is a Hall fault and turns every transistor off.
// R5 - Every other position state drives the transistors from the commutation table.
// R6 - The fault output stays high for as long as the Hall fault lasts.
// R7 - Rotation against the preset direction raises the fault output and trapezoidal drive within one step.
// R8 - Rotation in the preset direction leaves the reverse-rotation part of the fault output low.
// R9 - Comparator outputs are synchronised to the clock before any fault or direction decision.
`timescale 1ns/100ps
module hfds_top (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_b,
  input  wire hfds_pkg::hfds_hall_in_t hall_in,
  input  wire logic                   direction_select,
  output logic                        fault_out,
  output logic                        drive_sine,
  output hfds_pkg::hfds_gate_t        gate_en,
  output hfds_pkg::hfds_pos_t         position_sense
);

  // Commutation table: 120 degree step pattern, u=bit2 v=bit1 w=bit0
  function automatic hfds_pkg::hfds_gate_t commutate(input hfds_pkg::hfds_pos_t p);
    hfds_pkg::hfds_gate_t g;
    g = hfds_pkg::GATES_OFF;
    case (p)
      3'h5:    begin g.high_side = 3'h4; g.low_side = 3'h2; end
      3'h4:    begin g.high_side = 3'h4; g.low_side = 3'h1; end
      3'h6:    begin g.high_side = 3'h2; g.low_side = 3'h1; end
      3'h2:    begin g.high_side = 3'h2; g.low_side = 3'h4; end
      3'h3:    begin g.high_side = 3'h1; g.low_side = 3'h4; end
      3'h1:    begin g.high_side = 3'h1; g.low_side = 3'h2; end
      default: g = hfds_pkg::GATES_OFF;
    endcase
    return g;
  endfunction : commutate

  // Forward successor of a valid position state
  function automatic hfds_pkg::hfds_pos_t next_fwd(input hfds_pkg::hfds_pos_t p);
    hfds_pkg::hfds_pos_t n;
    n = p;
    case (p)
      3'h5:    n = 3'h4;
      3'h4:    n = 3'h6;
      3'h6:    n = 3'h2;
      3'h2:    n = 3'h3;
      3'h3:    n = 3'h1;
      3'h1:    n = 3'h5;
      default: n = p;
    endcase
    return n;
  endfunction : next_fwd

  // Last rotation direction seen between two valid position states.
  // Held across invalid states, so a brief Hall dropout does not lose it.
  typedef enum logic [0:0] {HFDS_ROT_FWD, HFDS_ROT_REV} hfds_rot_t;

  // Comparator outputs, one per phase
  // The analog compare is reduced to a digital one: a phase reads high
  // only when its positive input is up and its negative input is down.
  // An input pair that shows both high or both low reads as low, which
  // keeps a floating element from looking like a valid high phase.
  hfds_pkg::hfds_pos_t      cmp_bits;
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      cmp_bits[i] = hall_in.hall_positive_input[i] & ~hall_in.hall_negative_input[i]; // [R1]
  end

  // Two-stage synchroniser; stage one is read only by stage two
  hfds_pkg::hfds_pos_t sync1_r;
  hfds_pkg::hfds_pos_t pos_r;
  hfds_pkg::hfds_pos_t prev_r;
  hfds_rot_t           rot_r;
  hfds_rot_t           rot_nxt;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_r <= hfds_pkg::POS_RESET;
      pos_r   <= hfds_pkg::POS_RESET;
    end
    else
    begin
      sync1_r <= cmp_bits;
      pos_r   <= sync1_r; // [R9]
    end
  end

  // Decoding of the synchronised state
  wire hall_bad  = (pos_r == 3'h7) || (pos_r == 3'h0);     // [R4]
  wire prev_bad  = (prev_r == 3'h7) || (prev_r == 3'h0);
  wire step_seen = (pos_r != prev_r) && !hall_bad && !prev_bad;
  wire step_fwd  = step_seen && (next_fwd(prev_r) == pos_r);

  // Direction is judged at the first edge of each step, well inside 60 degrees
  always_comb
  begin
    rot_nxt = rot_r;
    if (step_seen)
      rot_nxt = step_fwd ? HFDS_ROT_FWD : HFDS_ROT_REV; // [R7]
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      prev_r <= hfds_pkg::POS_RESET;
      rot_r  <= HFDS_ROT_FWD;
    end
    else
    begin
      prev_r <= pos_r;
      rot_r  <= rot_nxt;
    end
  end

  wire rot_dir     = (rot_r == HFDS_ROT_REV) ? hfds_pkg::DIR_REV : hfds_pkg::DIR_FWD;
  wire against_dir = (rot_dir != direction_select);      // [R8]
  // Sine only when turning the preset way; covers both preset directions
  wire sine_sel    = against_dir ? hfds_pkg::DRIVE_TRAP : hfds_pkg::DRIVE_SINE; // [R2] [R3]
  wire fault_nxt   = hall_bad || against_dir;            // [R6] [R7]
  wire hfds_pkg::hfds_gate_t gate_nxt = hall_bad ? hfds_pkg::GATES_OFF // [R4]
                                                 : commutate(pos_r);   // [R5]

  // Registered outputs; one cycle after the decision
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fault_out      <= 1'h0;
      drive_sine     <= hfds_pkg::DRIVE_SINE;
      gate_en        <= hfds_pkg::GATES_OFF;
      position_sense <= hfds_pkg::POS_RESET;
    end
    else
    begin
      fault_out      <= fault_nxt;
      drive_sine     <= sine_sel;
      gate_en        <= gate_nxt;
      position_sense <= pos_r;
    end
  end

  // Checks
  a_hall_gates_off: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R4]
    hall_bad |=> (gate_en == hfds_pkg::GATES_OFF)) else $error("gates on during hall fault");
  a_hall_fault_hi: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R6]
    hall_bad |=> fault_out) else $error("fault low during hall fault");
  a_commut_table: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R5]
    !hall_bad |=> (gate_en == commutate($past(pos_r)))) else $error("commutation mismatch");
  a_sync_delay: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R9]
    ##2 (pos_r == $past(cmp_bits, 2))) else $error("sync path not two stages");
  a_rev_fault: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R7]
    (step_seen && !step_fwd && direction_select == hfds_pkg::DIR_FWD) ##1
    (direction_select == hfds_pkg::DIR_FWD) |=> fault_out && !drive_sine)
    else $error("reverse rotation not flagged");
  a_fwd_sine: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R2]
    (rot_r == HFDS_ROT_FWD && !direction_select) |=> drive_sine) else $error("expected sine");
  a_rev_preset_sine: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R3]
    (rot_r == HFDS_ROT_REV && direction_select) |=> drive_sine) else $error("expected sine");
  a_preset_no_fault: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R8]
    (!against_dir && !hall_bad) |=> !fault_out) else $error("spurious fault");
  a_drive_trap: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R2]
    (rot_r == HFDS_ROT_REV && !direction_select) |=> !drive_sine) else $error("expected trap");

  // Preset reverse while turning forward must fall back to trapezoidal
  a_preset_rev_trap: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R3]
    (rot_r == HFDS_ROT_FWD && direction_select) |=> !drive_sine) else $error("expected trap");

  // Any rotation against the preset way raises the fault output
  a_against_fault: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R7]
    against_dir |=> fault_out) else $error("fault low against preset");

  // Direction register tracks every valid step
  a_rev_step_seen: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R7]
    (step_seen && !step_fwd) |=> (rot_r == HFDS_ROT_REV)) else $error("reverse step missed");

  a_fwd_step_seen: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R8]
    (step_seen && step_fwd) |=> (rot_r == HFDS_ROT_FWD)) else $error("forward step missed");

  // Steps into or out of an invalid state must not move the direction
  a_rot_hold: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R4]
    !step_seen |=> $stable(rot_r)) else $error("direction moved without a step");

  // Valid states switch exactly one high side and one low side
  a_one_high_side: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R5]
    !hall_bad |=> $onehot(gate_en.high_side)) else $error("high side not one-hot");

  a_one_low_side: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R5]
    !hall_bad |=> $onehot(gate_en.low_side)) else $error("low side not one-hot");

  // Shoot-through guard: never both transistors of one phase
  a_no_shoot_thru: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R5]
    (gate_en.high_side & gate_en.low_side) == 3'h0) else $error("phase shoot-through");

  // Valid states never leave the bridge idle
  a_gates_active: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R5]
    !hall_bad |=> (gate_en != hfds_pkg::GATES_OFF)) else $error("gates idle in valid state");

  // Published position is the synchronised state, one edge late
  a_pos_follows: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R9]
    1'h1 |=> (position_sense == $past(pos_r))) else $error("position output stale");

  // Once the Hall fault ends the hall part of the fault output drops
  a_fault_release: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R6]
    (!hall_bad && !against_dir) |=> !fault_out) else $error("fault held after hall fault");

  // Drive style is a pure function of direction match, hall state aside
  a_sine_match: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R2] [R3]
    !against_dir |=> drive_sine) else $error("sine missing in preset direction");

  // Reverse preset with reverse rotation raises no fault of its own
  a_rev_preset_ok: assert property (@(posedge clk_sys) disable iff (!rst_b) // [R8]
    (rot_r == HFDS_ROT_REV && direction_select && !hall_bad) |=> !fault_out)
    else $error("fault while turning the preset way");

endmodule : hfds_top

// *** verification/hfds_hall_model.sv ***
// Hall element pair model feeding the position comparators
`timescale 1ns/100ps
module hfds_hall_model (
  input  wire logic                    clk_sys,
  input  wire hfds_pkg::hfds_pos_t     pos,
  output hfds_pkg::hfds_hall_in_t      hall_in
);
  logic [2:0] noise_r = 3'h0;

  // Fresh noise each cycle, so a low phase never shows one fixed pair
  always @(posedge clk_sys)
  begin
    noise_r <= 3'($urandom);
  end

  // High phase: pos over neg; low phase: neg high with pos random
  assign hall_in.hall_positive_input = pos | (~pos & noise_r);
  assign hall_in.hall_negative_input = ~pos;
endmodule : hfds_hall_model

// *** verification/testbench.sv ***
// Self-checking bench: random Hall walk, direction changes and fault checks
`timescale 1ns/100ps
module testbench;
  typedef struct packed {
    logic                 f;
    logic                 s;
    hfds_pkg::hfds_gate_t g;
    hfds_pkg::hfds_pos_t  p;
  } hfds_tb_exp_t;
  localparam hfds_pkg::hfds_pos_t SEQ [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
  logic                    clk_sys          = 1'b0;
  logic                    rst_b            = 1'b0;
  logic                    direction_select = 1'b0;
  logic                    sample           = 1'b0;
  logic                    rot              = 1'b0;
  hfds_pkg::hfds_pos_t     pos              = 3'h5;
  hfds_pkg::hfds_pos_t     lastv            = 3'h5;
  hfds_pkg::hfds_hall_in_t hall_in;
  logic                    fault_out;
  logic                    drive_sine;
  hfds_pkg::hfds_gate_t    gate_en;
  hfds_pkg::hfds_pos_t     position_sense;
  hfds_tb_exp_t            exp_q [$];
  hfds_tb_exp_t            exp_v;
  int                      error_cnt   = 0;
  int                      comparisons = 0;

  hfds_top hfds_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .hall_in(hall_in),
    .direction_select(direction_select), .fault_out(fault_out),
    .drive_sine(drive_sine), .gate_en(gate_en), .position_sense(position_sense));
  hfds_hall_model hfds_hall_model_i (.clk_sys(clk_sys), .pos(pos), .hall_in(hall_in));

  // 100 MHz clock
  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  // Six-step table, high side then low side, bit 2 = u
  function automatic hfds_pkg::hfds_gate_t commut(input hfds_pkg::hfds_pos_t p);
    case (p)
      3'h5: return '{3'h4, 3'h2};
      3'h4: return '{3'h4, 3'h1};
      3'h6: return '{3'h2, 3'h1};
      3'h2: return '{3'h2, 3'h4};
      3'h3: return '{3'h1, 3'h4};
      3'h1: return '{3'h1, 3'h2};
      default: return hfds_pkg::GATES_OFF;
    endcase
  endfunction : commut

  // Kind 0 forward, 1 reverse, 2 invalid state, 3 flip preset direction
  task automatic step(input int kind);
    hfds_pkg::hfds_pos_t nxt;
    int                  i;
    logic                bad;
    i = 0;
    nxt = pos;
    for (int k = 0; k < 6; k++)
      if (SEQ[k] == lastv) i = k;
    if (kind == 0) nxt = SEQ[(i + 1) % 6];
    if (kind == 1) nxt = SEQ[(i + 5) % 6];
    if (kind == 2) nxt = ($urandom_range(1, 0) != 0) ? 3'h7 : 3'h0;
    // Steps out of an invalid state carry no direction
    if (kind < 2 && pos != 3'h0 && pos != 3'h7) rot = kind[0];
    if (kind < 2) lastv = nxt;
    @(posedge clk_sys);
    pos <= nxt;
    if (kind == 3) direction_select <= ~direction_select;
    repeat (6) @(posedge clk_sys);
    bad = (pos == 3'h0) || (pos == 3'h7);
    exp_q.push_back('{bad | (rot != direction_select), rot == direction_select,
                      commut(pos), pos});
    sample <= 1'b1;
    @(posedge clk_sys);
    sample <= 1'b0;
  endtask : step

  // Watcher: oldest note against what the outputs show
  always @(posedge clk_sys)
  begin
    if (sample && exp_q.size() > 0)
    begin
      exp_v = exp_q.pop_front();
      comparisons++;
      if ({fault_out, drive_sine, gate_en, position_sense} !== exp_v)
      begin
        $display("wrong value at %0t: got %h expected %h", $time,
                 {fault_out, drive_sine, gate_en, position_sense}, exp_v);
        error_cnt++;
      end
    end
  end

  task automatic final_report();
    if (error_cnt == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Main sequence: every kind twice, then a random walk
  initial
  begin
    void'($urandom(32'h0ee8));
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int k = 0; k < 8; k++) step(k % 4);
    repeat (200) step(int'($urandom_range(3, 0)));
    @(posedge clk_sys);
    final_report();
  end

  // Hang guard, about 2.4 times the expected run
  initial
  begin
    repeat (4000) @(posedge clk_sys);
    error_cnt++;
    final_report();
  end
endmodule : testbench
